// >>> include/quad_enc_pkg.sv
// constants, field positions and carriers for the quadrature encoder controller
package quad_enc_pkg;

	// register word indices on the plain register port
	localparam logic [2:0] ADDR_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_FILT   = 3'h1;
	localparam logic [2:0] ADDR_POS    = 3'h2;
	localparam logic [2:0] ADDR_MAX    = 3'h3;
	localparam logic [2:0] ADDR_IRQ    = 3'h4;

	// control/status field positions
	localparam int CS_ERR      = 15;
	localparam int CS_IDLE     = 13;
	localparam int CS_INDEX    = 12;
	localparam int CS_DIR      = 11;
	localparam int CS_MODE_LO  = 8;
	localparam int CS_SWAP     = 7;
	localparam int CS_DIROUT   = 6;
	localparam int CS_GATE     = 5;
	localparam int CS_PS_LO    = 3;
	localparam int CS_IDXRES   = 2;
	localparam int CS_TCLK     = 1;
	localparam int CS_DIRSRC   = 0;

	// filter control field positions
	localparam int FC_IMV_LO   = 9;
	localparam int FC_COUNT_ERR_IRQ_DISABLE     = 8;
	localparam int FC_FOUT     = 7;
	localparam int FC_DIV_LO   = 4;

	// writable masks (unimplemented bits read zero)
	localparam logic [15:0] CS_WMASK   = 16'hA7FF;
	localparam logic [15:0] FC_WMASK   = 16'h07F0;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// irq register bits
	localparam int IRQ_FLAG    = 0;
	localparam int IRQ_EN      = 1;

	// mode_select encodings
	localparam logic [2:0] MODE_OFF    = 3'h0;
	localparam logic [2:0] MODE_TIMER  = 3'h1;
	localparam logic [2:0] MODE_X2_IDX = 3'h4;
	localparam logic [2:0] MODE_X2_MAT = 3'h5;
	localparam logic [2:0] MODE_X4_IDX = 3'h6;
	localparam logic [2:0] MODE_X4_MAT = 3'h7;

	localparam logic [15:0] ALL_ONES   = 16'hFFFF;
	localparam logic [15:0] ONE16      = 16'h0001;
	localparam logic [7:0]  PS_DIV8    = 8'h07;
	localparam logic [7:0]  PS_DIV64   = 8'h3F;
	localparam logic [7:0]  PS_DIV256  = 8'hFF;
	localparam int          FILT_STABLE = 3;

	typedef struct packed {
		logic a;
		logic b;
		logic idx;
	} enc_pins_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [15:0] wdata;
		logic [1:0] be;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// >>> sim/enc_model.sv
// incremental encoder model: two phases in quadrature and an index pulse
`timescale 1ns/100ps
module enc_model (
	input  wire logic i_mclk,
	output logic      o_a,
	output logic      o_b,
	output logic      o_idx
);
	logic [1:0] ph_q = 2'h0;
	assign o_a = ph_q == 2'h1 || ph_q == 2'h2;
	assign o_b = ph_q[1];
	initial o_idx = 1'b0;
	// one step, a leads b when up; slow enough for sync and filter
	task automatic step(input logic up);
		@(posedge i_mclk);
		ph_q <= up ? ph_q + 2'h1 : ph_q - 2'h1;
		repeat (12) @(posedge i_mclk);
	endtask
	// index pulse while both phases are low
	task automatic pulse_idx();
		@(posedge i_mclk);
		o_idx <= 1'b1;
		repeat (12) @(posedge i_mclk);
		o_idx <= 1'b0;
		repeat (12) @(posedge i_mclk);
	endtask
endmodule

// >>> sim/quad_enc_monitor.sv
// port assertions for the encoder controller
`timescale 1ns/100ps
module quad_enc_monitor (
	input wire logic        i_mclk,
	input wire logic        i_rstn,
	input wire logic        i_cpu_idle,
	input wire logic        i_phase_a_in,
	input wire logic        i_phase_b_in,
	input wire logic        i_index_in,
	input wire logic [2:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic [1:0]  i_be,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_irq,
	input wire logic        o_dir_pin,
	input wire logic        o_dir_pin_oe
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	logic wc;
	logic rc;
	logic wf;
	logic rf;
	assign wc = i_wr && i_addr == quad_enc_pkg::ADDR_CTRL && i_be == 2'h3;
	assign rc = i_rd && i_addr == quad_enc_pkg::ADDR_CTRL;
	assign wf = i_wr && i_addr == quad_enc_pkg::ADDR_FILT && i_be == 2'h3;
	assign rf = i_rd && i_addr == quad_enc_pkg::ADDR_FILT;
	chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside read slot");
	chk_unmapped_zero: assert property (i_rd && i_addr > 3'h4 |=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_ctrl_readback: assert property (wc ##1 !i_wr ##1 rc |=> o_rdata[14] == 1'b0 &&
		o_rdata[13] == $past(i_wdata[13], 3) && o_rdata[10:0] == $past(i_wdata[10:0], 3))
		else $error("control readback wrong");
	chk_filt_readback: assert property (wf ##1 !i_wr ##1 rf |=> o_rdata == ($past(i_wdata, 3) & quad_enc_pkg::FC_WMASK))
		else $error("filter readback wrong");
	chk_max_byte: assert property ((i_wr && i_addr == quad_enc_pkg::ADDR_MAX && i_be == 2'h1) ##1 !i_wr ##1
		(i_rd && i_addr == quad_enc_pkg::ADDR_MAX) |=> o_rdata[7:0] == $past(i_wdata[7:0], 3))
		else $error("byte write lost");
	chk_oe_follows: assert property (i_wr && i_addr == quad_enc_pkg::ADDR_CTRL && i_be[0] |->
		##2 o_dir_pin_oe == $past(i_wdata[6], 2))
		else $error("direction pin enable wrong");
	chk_irq_gate: assert property (i_wr && i_addr == quad_enc_pkg::ADDR_IRQ && i_be[0] && !i_wdata[1] |->
		##2 !o_irq)
		else $error("irq raised while disabled");
	chk_irq_sticky: assert property ($fell(o_irq) |-> $past(i_wr && i_addr == quad_enc_pkg::ADDR_IRQ, 2))
		else $error("irq dropped without software");
	cover property (wc ##1 !i_wr ##1 rc);
	cover property ($rose(o_irq));
	cover property ($fell(o_irq));
endmodule
bind quad_enc_ctrl quad_enc_monitor quad_enc_monitor_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cpu_idle(i_cpu_idle),
	.i_phase_a_in(i_phase_a_in), .i_phase_b_in(i_phase_b_in), .i_index_in(i_index_in), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_be(i_be), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_dir_pin(o_dir_pin), .o_dir_pin_oe(o_dir_pin_oe));

// >>> sim/quadrature_encoder_control_test.sv
// self-checking bench for the encoder controller
`timescale 1ns/100ps
module quadrature_encoder_control_test;
	logic        i_mclk;
	logic        i_rstn;
	logic        i_cpu_idle;
	logic        i_wr;
	logic        i_rd;
	logic [2:0]  i_addr;
	logic [15:0] i_wdata;
	logic [1:0]  i_be;
	logic [15:0] o_rdata;
	logic [15:0] rv;
	logic [15:0] r1;
	logic        o_irq;
	logic        o_dir_pin;
	logic        o_dir_pin_oe;
	logic        pa;
	logic        pb;
	logic        px;
	int          err_count = 0;
	int          compares = 0;
	typedef struct {logic [2:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] e;} row_t;
	typedef struct {logic [15:0] c; logic idle; logic [15:0] e;} trow_t;
	logic [15:0] rst_exp[6] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
	row_t        rows[7] = '{'{3'h0, 16'h20D5, 2'h3, 16'h20D5}, '{3'h1, 16'hFFFF, 2'h3, 16'h07F0},
		'{3'h3, 16'h1234, 2'h1, 16'hFF34}, '{3'h3, 16'hAB00, 2'h2, 16'hAB34},
		'{3'h2, 16'h0005, 2'h3, 16'h0005}, '{3'h5, 16'hFFFF, 2'h3, 16'h0000}, '{3'h4, 16'h0002, 2'h3, 16'h0002}};
	trow_t       tm[9] = '{'{16'h0900, 1'b0, 16'h0100}, '{16'h0908, 1'b0, 16'h0020}, '{16'h0910, 1'b0, 16'h0004},
		'{16'h0918, 1'b0, 16'h0001}, '{16'h2900, 1'b1, 16'h0000}, '{16'h0900, 1'b1, 16'h0100},
		'{16'h0100, 1'b0, 16'hFF00}, '{16'h0902, 1'b0, 16'h0000}, '{16'h0901, 1'b0, 16'hFF00}};
	quad_enc_ctrl quad_enc_ctrl_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cpu_idle(i_cpu_idle),
		.i_phase_a_in(pa), .i_phase_b_in(pb), .i_index_in(px), .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_dir_pin(o_dir_pin),
		.o_dir_pin_oe(o_dir_pin_oe));
	enc_model enc_model_i (.i_mclk(i_mclk), .o_a(pa), .o_b(pb), .o_idx(px));
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		i_be <= be;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		d = o_rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
		rd(a, rv);
		chk(rv, exp);
	endtask
	task automatic cnt(input logic [15:0] c, f, mx, input int n, input logic up);
		wr(3'h0, 16'h0000, 2'h3);
		wr(3'h1, f, 2'h3);
		wr(3'h3, mx, 2'h3);
		wr(3'h2, 16'h0000, 2'h3);
		wr(3'h0, c, 2'h3);
		repeat (n) enc_model_i.step(up);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#2_000_000;
		err_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		test_done();
	end
	initial begin
		i_rstn = 1'b0;
		i_cpu_idle = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 3'h0;
		i_wdata = 16'h0000;
		i_be = 2'h0;
		repeat (20) @(posedge i_mclk);
		i_rstn <= 1'b1;
		foreach (rst_exp[i]) rchk(3'(i), rst_exp[i]);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].be);
			rchk(rows[i].a, rows[i].e);
		end
		for (int m = 0; m < 8; m++) begin
			wr(3'h0, {5'h00, 3'(m), 8'h00}, 2'h3);
			rchk(3'h0, {5'h00, 3'(m), 8'h00});
			wr(3'h1, {9'h000, 3'(m), 4'h0}, 2'h3);
			rchk(3'h1, {9'h000, 3'(m), 4'h0});
		end
		cnt(16'h0740, 16'h0000, 16'hFFFF, 4, 1'b1);
		rchk(3'h2, 16'h0004);
		chk({15'h0000, o_dir_pin}, 16'h0001);
		chk({15'h0000, o_dir_pin_oe}, 16'h0001);
		cnt(16'h0500, 16'h0000, 16'hFFFF, 4, 1'b1);
		rchk(3'h2, 16'h0002);
		cnt(16'h0780, 16'h0000, 16'hFFFF, 4, 1'b1);
		rchk(3'h2, 16'hFFFC);
		cnt(16'h0700, 16'h0080, 16'hFFFF, 4, 1'b1);
		rchk(3'h2, 16'h0004);
		wr(3'h4, 16'h0000, 2'h3);
		cnt(16'h0700, 16'h0000, 16'h0003, 5, 1'b1);
		rchk(3'h2, 16'h0001);
		rchk(3'h4, 16'h0001);
		repeat (30) @(posedge i_mclk);
		rchk(3'h4, 16'h0001);
		wr(3'h4, 16'h0003, 2'h3);
		repeat (2) @(negedge i_mclk);
		chk({15'h0000, o_irq}, 16'h0001);
		wr(3'h4, 16'h0002, 2'h3);
		rchk(3'h4, 16'h0002);
		chk({15'h0000, o_irq}, 16'h0000);
		cnt(16'h0604, 16'h0000, 16'h0100, 3, 1'b1);
		rchk(3'h2, 16'h0003);
		wr(3'h4, 16'h0002, 2'h3);
		enc_model_i.pulse_idx();
		rchk(3'h2, 16'h0000);
		rchk(3'h4, 16'h0003);
		wr(3'h4, 16'h0002, 2'h3);
		enc_model_i.step(1'b0);
		rchk(3'h2, 16'hFFFF);
		enc_model_i.step(1'b1);
		rchk(3'h0, 16'h8E04);
		rchk(3'h4, 16'h0003);
		wr(3'h0, 16'h0604, 2'h3);
		rchk(3'h0, 16'h0E04);
		wr(3'h1, 16'h0100, 2'h3);
		wr(3'h4, 16'h0002, 2'h3);
		enc_model_i.step(1'b0);
		rchk(3'h4, 16'h0002);
		rchk(3'h0, 16'h8604);
		enc_model_i.step(1'b1);
		wr(3'h3, 16'hFFFF, 2'h3);
		foreach (tm[i]) begin
			wr(3'h0, 16'h0100, 2'h3);
			wr(3'h0, tm[i].c, 2'h3);
			i_cpu_idle <= tm[i].idle;
			repeat (8) @(posedge i_mclk);
			rd(3'h2, r1);
			repeat (254) @(posedge i_mclk);
			rd(3'h2, rv);
			chk(rv - r1, tm[i].e);
		end
		wr(3'h0, 16'h0920, 2'h3);
		wr(3'h4, 16'h0002, 2'h3);
		rd(3'h2, r1);
		enc_model_i.step(1'b1);
		enc_model_i.step(1'b0);
		rd(3'h2, rv);
		chk(rv - r1, 16'h000D);
		rchk(3'h4, 16'h0003);
		i_cpu_idle <= 1'b0;
		test_done();
	end
endmodule

// >>> src/quad_enc_ctrl.sv
// quadrature encoder controller with alternate up/down timer and input filters
`timescale 1ns/100ps

// Function
// R01: in timer mode during idle, keep counting if idle_stop is 0, halt if 1.
// R02: idle_stop resets to zero so the module runs during idle by default.
// R03: rollover, qualified index, count error, period match, gate event set irq flag.
// R04: irq flag stays set until software clears it.
// R05: interrupt request raised only when flag and irq enable are both set.
// R06: all four registers accept byte and word reads and writes.
// R07: software uses word accesses on position count or stops counting.
// R08: count error flag at bit 15, meaningful only in modes 110 and 100.
// R09: bit 12 reads the current index level.
// R10: direction bit 11, read-only in modes 1xx, writable in mode 001.
// R11: mode field decodes x4/x2 with match or index reset, timer, off.
// R12: phase_swap exchanges phase A and B before decoding.
// R13: direction_pin_output_en drives direction onto its pin.
// R14: gated_accum_en enables gated time accumulation of the timer.
// R15: timer_prescale divides timer clock 1, 8, 64, 256; timer mode only.
// R16: index_reset_en lets a detected index clear position count in index modes.
// R17: timer_clk_source selects phase A rising edges or instruction cycles.
// R18: in timer mode direction_source picks phase B pin or direction bit.
// R19: index_match_value qualifies index by phase levels, differently in x4 and x2.
// R20: count_err_irq_disable blocks count error interrupts.
// R21: filter_output_en selects filtered or raw inputs.
// R22: filter_clk_divide sets filter sample divide 1 to 256.
// R23: filter output changes after three stable consecutive filter samples.
// R24: index modes flag error when count reaches FFFF or max_count plus one.
// R25: x4 counts every edge of both phases; x2 only phase A edges.
// R26: timer mode uses max_count as period; match sets irq flag.
// R27: match-reset and timer modes reload zero on the count after equality; counting down from zero the code reloads max_count instead.
// R28: count error flag stays until software writes zero.
module quad_enc_ctrl (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_cpu_idle,
	input  wire logic        i_phase_a_in,
	input  wire logic        i_phase_b_in,
	input  wire logic        i_index_in,
	input  wire logic [2:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [1:0]  i_be,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	output logic             o_irq,
	output logic             o_dir_pin,
	output logic             o_dir_pin_oe
);

	quad_enc_pkg::reg_req_t  req;
	quad_enc_pkg::enc_pins_t raw_s1_q;
	quad_enc_pkg::enc_pins_t raw_q;
	quad_enc_pkg::enc_pins_t flt_q;
	quad_enc_pkg::enc_pins_t sel;
	quad_enc_pkg::enc_pins_t prev_q;
	logic [15:0] ctrl_q;
	logic [15:0] filt_q;
	logic [15:0] pos_q;
	logic [15:0] max_q;
	logic        dir_q;
	logic        err_q;
	logic        irq_flag_q;
	logic        irq_en_q;
	logic        idle_s1_q;
	logic        idle_q;
	logic [7:0]  fdiv_q;
	logic        fstb;
	logic [1:0]  fcnt_q [3];
	logic [2:0]  fcand_q;
	logic [7:0]  pre_q;
	logic        gate_q;
	logic        qa;
	logic        qb;
	logic        qidx;
	logic [2:0]  mode;
	logic        enc_mode;
	logic        x4_mode;
	logic        idx_mode;
	logic        timer_mode;
	logic        a_edge;
	logic        b_edge;
	logic        enc_step;
	logic        enc_up;
	logic        idx_rise;
	logic        idx_qual;
	logic        tmr_tick;
	logic        tmr_step;
	logic        tmr_up;
	logic        step;
	logic        up;
	logic        match_max;
	logic        err_hit;
	logic        roll_evt;
	logic        gate_evt;
	logic        run;
	logic [7:0]  ps_lim;
	logic [7:0]  fdiv_lim;

	assign req = '{addr: i_addr, wdata: i_wdata, be: i_be, wr: i_wr, rd: i_rd};

	// byte-lane merge for writes
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be, input logic [15:0] wmask);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}} & wmask;
		merge = (old & ~m) | (nw & m);
	endfunction

	function automatic logic [7:0] div_limit(input logic [2:0] code);
		unique case (code)
			3'h0: div_limit = 8'h00;
			3'h1: div_limit = 8'h01;
			3'h2: div_limit = 8'h03;
			3'h3: div_limit = 8'h0F;
			3'h4: div_limit = 8'h1F;
			3'h5: div_limit = 8'h3F;
			3'h6: div_limit = 8'h7F;
			default: div_limit = 8'hFF;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			raw_s1_q  <= '0;
			raw_q     <= '0;
			idle_s1_q <= 1'b0;
			idle_q    <= 1'b0;
		end else begin
			raw_s1_q  <= '{a: i_phase_a_in, b: i_phase_b_in, idx: i_index_in};
			raw_q     <= raw_s1_q;
			idle_s1_q <= i_cpu_idle;
			idle_q    <= idle_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// digital noise filters
	assign fdiv_lim = div_limit(filt_q[quad_enc_pkg::FC_DIV_LO +: 3]);
	// a lower divide written mid-count must not stall the filter for a full wrap
	assign fstb     = (fdiv_q >= fdiv_lim);

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			fdiv_q <= 8'h00;
		end else if (fstb) begin // R22
			fdiv_q <= 8'h00;
		end else begin
			fdiv_q <= fdiv_q + 8'h01;
		end
	end

	generate
		for (genvar g = 0; g < 3; g++) begin : g_filt
			always_ff @(posedge i_mclk) begin
				if (!i_rstn) begin
					fcnt_q[g]  <= 2'h0;
					fcand_q[g] <= 1'b0;
				end else if (fstb) begin
					if (raw_q[g] != fcand_q[g]) begin
						fcand_q[g] <= raw_q[g];
						fcnt_q[g]  <= 2'h1;
					end else if (fcnt_q[g] != 2'(quad_enc_pkg::FILT_STABLE)) begin
						fcnt_q[g] <= fcnt_q[g] + 2'h1;
					end
				end
			end
			always_ff @(posedge i_mclk) begin
				if (!i_rstn) begin
					flt_q[g] <= 1'b0;
				end else if (fstb && raw_q[g] == fcand_q[g]
					&& fcnt_q[g] == 2'(quad_enc_pkg::FILT_STABLE - 1)) begin // R23
					flt_q[g] <= fcand_q[g];
				end
			end
		end
	endgenerate

	assign sel  = filt_q[quad_enc_pkg::FC_FOUT] ? flt_q : raw_q; // R21
	assign qa   = ctrl_q[quad_enc_pkg::CS_SWAP] ? sel.b : sel.a; // R12
	assign qb   = ctrl_q[quad_enc_pkg::CS_SWAP] ? sel.a : sel.b; // R12
	assign qidx = sel.idx;

	////////////////////////////////////////////////////////////////////////////
	// decode
	assign mode       = ctrl_q[quad_enc_pkg::CS_MODE_LO +: 3]; // R11
	assign enc_mode   = mode[2];
	assign x4_mode    = (mode == quad_enc_pkg::MODE_X4_IDX) || (mode == quad_enc_pkg::MODE_X4_MAT);
	assign idx_mode   = (mode == quad_enc_pkg::MODE_X4_IDX) || (mode == quad_enc_pkg::MODE_X2_IDX);
	assign timer_mode = (mode == quad_enc_pkg::MODE_TIMER);
	assign run        = !(idle_q && ctrl_q[quad_enc_pkg::CS_IDLE]); // R01

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			prev_q <= '0;
		end else begin
			prev_q <= '{a: qa, b: qb, idx: qidx};
		end
	end

	assign a_edge   = qa != prev_q.a;
	assign b_edge   = qb != prev_q.b;
	assign enc_step = enc_mode && (x4_mode ? (a_edge || b_edge) : a_edge); // R25
	// forward when A leads B
	assign enc_up   = a_edge ? (qa != qb) : (qa == qb);
	assign idx_rise = qidx && !prev_q.idx;
	// R19
	assign idx_qual = idx_rise && (x4_mode ?
		(qb == filt_q[quad_enc_pkg::FC_IMV_LO + 1] && qa == filt_q[quad_enc_pkg::FC_IMV_LO]) :
		((filt_q[quad_enc_pkg::FC_IMV_LO + 1] ? qb : qa) == filt_q[quad_enc_pkg::FC_IMV_LO]));

	////////////////////////////////////////////////////////////////////////////
	// timer clock, prescaler and gate
	always_comb begin
		unique case (ctrl_q[quad_enc_pkg::CS_PS_LO +: 2]) // R15
			2'h0: ps_lim = 8'h00;
			2'h1: ps_lim = quad_enc_pkg::PS_DIV8;
			2'h2: ps_lim = quad_enc_pkg::PS_DIV64;
			default: ps_lim = quad_enc_pkg::PS_DIV256;
		endcase
	end

	// R17
	assign tmr_tick = ctrl_q[quad_enc_pkg::CS_TCLK] ? (qa && !prev_q.a) : 1'b1;
	// R14: in gated mode the timer only accumulates while phase A is high
	assign tmr_step = timer_mode && run && tmr_tick && (pre_q >= ps_lim)
		&& (!ctrl_q[quad_enc_pkg::CS_GATE] || qa);
	assign gate_evt = timer_mode && ctrl_q[quad_enc_pkg::CS_GATE] && gate_q && !qa; // R14
	assign tmr_up   = ctrl_q[quad_enc_pkg::CS_DIRSRC] ? qb : dir_q; // R18

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			pre_q <= 8'h00;
		end else if (!timer_mode || !run) begin
			pre_q <= pre_q;
		end else if (tmr_tick && (!ctrl_q[quad_enc_pkg::CS_GATE] || qa)) begin
			pre_q <= (pre_q >= ps_lim) ? 8'h00 : pre_q + 8'h01;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			gate_q <= 1'b0;
		end else begin
			gate_q <= qa;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// position counter
	assign step      = timer_mode ? tmr_step : (enc_step && run);
	assign up        = timer_mode ? tmr_up : enc_up;
	assign match_max = up ? (pos_q == max_q) : (pos_q == 16'h0000);
	// R24
	assign err_hit   = idx_mode && enc_mode && ((pos_q == quad_enc_pkg::ALL_ONES)
		|| ({1'b0, pos_q} == {1'b0, max_q} + {1'b0, quad_enc_pkg::ONE16}));
	assign roll_evt  = step && !idx_mode && match_max; // R26

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			pos_q <= quad_enc_pkg::RESET_WORD;
		end else if (req.wr && req.addr == quad_enc_pkg::ADDR_POS) begin // R06
			pos_q <= merge(pos_q, req.wdata, req.be, quad_enc_pkg::ALL_ONES);
		end else if (idx_mode && enc_mode && idx_qual && ctrl_q[quad_enc_pkg::CS_IDXRES]) begin // R16
			pos_q <= 16'h0000;
		end else if (step) begin
			if (!idx_mode && match_max) begin // R27
				pos_q <= up ? 16'h0000 : max_q;
			end else begin
				pos_q <= up ? pos_q + quad_enc_pkg::ONE16 : pos_q - quad_enc_pkg::ONE16;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			dir_q <= 1'b0;
		end else if (enc_mode && enc_step) begin // R10
			dir_q <= enc_up;
		end else if (timer_mode && req.wr && req.be[1] && req.addr == quad_enc_pkg::ADDR_CTRL) begin // R10
			dir_q <= req.wdata[quad_enc_pkg::CS_DIR];
		end
	end

	// set wins over software clear
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			err_q <= 1'b0;
		end else if (err_hit) begin // R08
			err_q <= 1'b1;
		end else if (req.wr && req.be[1] && req.addr == quad_enc_pkg::ADDR_CTRL
			&& !req.wdata[quad_enc_pkg::CS_ERR]) begin // R28
			err_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ctrl_q <= quad_enc_pkg::RESET_WORD; // R02
			filt_q <= quad_enc_pkg::RESET_WORD;
			max_q  <= quad_enc_pkg::ALL_ONES;
		end else if (req.wr) begin
			if (req.addr == quad_enc_pkg::ADDR_CTRL) begin // R06
				ctrl_q <= merge(ctrl_q, req.wdata, req.be, quad_enc_pkg::CS_WMASK);
			end
			if (req.addr == quad_enc_pkg::ADDR_FILT) begin
				filt_q <= merge(filt_q, req.wdata, req.be, quad_enc_pkg::FC_WMASK);
			end
			if (req.addr == quad_enc_pkg::ADDR_MAX) begin
				max_q <= merge(max_q, req.wdata, req.be, quad_enc_pkg::ALL_ONES);
			end
		end
	end

	// R03 R04 R20
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			irq_flag_q <= 1'b0;
		end else if (roll_evt || (idx_mode && enc_mode && idx_qual) || gate_evt
			|| (err_hit && !err_q && !filt_q[quad_enc_pkg::FC_COUNT_ERR_IRQ_DISABLE])) begin
			irq_flag_q <= 1'b1;
		end else if (req.wr && req.be[0] && req.addr == quad_enc_pkg::ADDR_IRQ
			&& !req.wdata[quad_enc_pkg::IRQ_FLAG]) begin
			irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			irq_en_q <= 1'b0;
		end else if (req.wr && req.be[0] && req.addr == quad_enc_pkg::ADDR_IRQ) begin
			irq_en_q <= req.wdata[quad_enc_pkg::IRQ_EN];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= irq_flag_q && irq_en_q; // R05
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_dir_pin    <= 1'b0;
			o_dir_pin_oe <= 1'b0;
		end else begin
			o_dir_pin    <= dir_q;
			o_dir_pin_oe <= ctrl_q[quad_enc_pkg::CS_DIROUT]; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port: data in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_mclk) begin
		if (!i_rstn || !req.rd) begin
			o_rdata <= 16'h0000;
		end else begin
			unique case (req.addr)
				quad_enc_pkg::ADDR_CTRL: begin
					o_rdata <= {err_q, 1'b0, ctrl_q[quad_enc_pkg::CS_IDLE], qidx, dir_q,
						ctrl_q[quad_enc_pkg::CS_MODE_LO + 2:0]}; // R09
				end
				quad_enc_pkg::ADDR_FILT: o_rdata <= filt_q;
				quad_enc_pkg::ADDR_POS:  o_rdata <= pos_q;
				quad_enc_pkg::ADDR_MAX:  o_rdata <= max_q;
				quad_enc_pkg::ADDR_IRQ:  o_rdata <= {14'h0000, irq_en_q, irq_flag_q};
				default:                 o_rdata <= 16'h0000;
			endcase
		end
	end

endmodule
